/* File: rtl/hsid_pkg.sv */
package hsid_pkg;

  // Register byte offsets (word aligned)
  localparam logic [5:0] OFS_DESC_LOW   = 6'h00;
  localparam logic [5:0] OFS_ENDP_HIGH  = 6'h04;
  localparam logic [5:0] OFS_POLL_FRAME = 6'h08;
  localparam logic [5:0] OFS_UF_MASK    = 6'h0C;
  localparam logic [5:0] OFS_STATUS     = 6'h10;
  localparam logic [5:0] OFS_DONE_BYTES = 6'h14;

  // Lowest descriptor word field layout
  localparam int EP_LOW_BIT  = 31;
  localparam int MULT_HI     = 30;
  localparam int MULT_LO     = 29;
  localparam int MAXPKT_HI   = 28;
  localparam int MAXPKT_LO   = 18;
  localparam int XFER_HI     = 17;
  localparam int XFER_LO     = 3;
  localparam int VALID_BIT   = 0;

  // Field widths
  localparam int MAXPKT_W    = 11;
  localparam int XFER_W      = 15;
  localparam int MULT_W      = 2;
  localparam int EPHI_W      = 3;
  localparam int FRAME_W     = 5;
  localparam int UFRAME_W    = 3;
  localparam int UFMASK_W    = 8;

  // Polling field: frame rate code lives in bits 7..3
  localparam int POLL_RATE_HI = 7;
  localparam int POLL_RATE_LO = 3;

  // Status register layout
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_ERR_BIT   = 1;
  localparam int ST_DONE_BIT  = 2;
  localparam int ST_LEFT_LO   = 4;
  localparam int ST_LEFT_HI   = 5;
  localparam int ST_REM_LO    = 16;
  localparam int ST_REM_HI    = 30;

  // Reset values
  localparam logic [31:0] RST_DESC_LOW = 32'h0000_0000;
  localparam logic [2:0]  RST_EP_HIGH  = 3'h0;
  localparam logic [7:0]  RST_POLL     = 8'h00;
  localparam logic [7:0]  RST_UF_MASK  = 8'h00;

  // Scheduler states, Gray along idle -> issue -> wait
  typedef enum logic [1:0] {
    HSID_IDLE  = 2'b00,
    HSID_ISSUE = 2'b01,
    HSID_WAIT  = 2'b11
  } hsid_state_e;

endpackage

/* File: rtl/hsid_poll_match.sv */
`timescale 1ns/1ps
`default_nettype none

module hsid_poll_match (
  input  wire logic [4:0] rate_code,
  input  wire logic [4:0] frame_num,
  input  wire logic [2:0] uframe_idx,
  input  wire logic [7:0] uf_mask,
  output logic            poll_hit
);

  logic [4:0] period_mask;
  logic       frame_hit;
  logic       uf_hit;

  // Mask of frame bits that select the period: smear of the rate code
  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1) begin : g_smear
      assign period_mask[i] = |rate_code[4:i];
    end
  endgenerate

  // Code zero gives an empty mask, so every frame matches
  assign frame_hit = (((frame_num ^ rate_code) & period_mask) == 5'h00);
  assign uf_hit    = uf_mask[uframe_idx];
  assign poll_hit  = frame_hit & uf_hit;

endmodule

`default_nettype wire

/* File: rtl/hsid_top.sv */
// How it works
// - Multiplier gives packets per descriptor execution
// - Max packet field limits each packet
// - Byte count field is total payload
// - Hardware clears valid on finish or fatal
// - Bit 31 is endpoint low bit
// - Issue only on frame match, mask bit
// - Period is two to b-1 microframes
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module hsid_top (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Bus frame timing from the controller
  input  wire logic        usof_pulse,
  input  wire logic [4:0]  frame_num,
  input  wire logic [2:0]  uframe_idx,
  // Transaction engine side
  output logic             txn_start,
  output logic [3:0]       txn_endpoint,
  output logic [10:0]      txn_len,
  input  wire logic        txn_done,
  input  wire logic [10:0] txn_bytes,
  input  wire logic        txn_fatal,
  output logic             desc_valid
);

  logic [31:0]              desc_low;
  logic [2:0]               ep_high;
  logic [7:0]               poll_frame;
  logic [7:0]               uf_mask;
  logic [14:0]              bytes_left;
  logic [14:0]              bytes_done;
  logic [1:0]               pkts_left;
  logic                     err_flag;
  logic                     done_flag;
  logic                     rd_ready;
  hsid_pkg::hsid_state_e    state;
  hsid_pkg::hsid_state_e    next_state;

  // Decoded state flags, shared by the datapath and the outputs
  wire logic                st_idle;
  wire logic                st_issue;
  wire logic                st_wait;
  assign st_idle  = (state == hsid_pkg::HSID_IDLE);
  assign st_issue = (state == hsid_pkg::HSID_ISSUE);
  assign st_wait  = (state == hsid_pkg::HSID_WAIT);

  // Descriptor fields
  wire logic [1:0]          mult_f;
  wire logic [10:0]         maxpkt_f;
  wire logic                valid_f;
  wire logic                ep_low_f;
  // Byte count field is only read when the descriptor is armed
  assign mult_f   = desc_low[hsid_pkg::MULT_HI:hsid_pkg::MULT_LO];
  assign maxpkt_f = desc_low[hsid_pkg::MAXPKT_HI:hsid_pkg::MAXPKT_LO];
  assign valid_f  = desc_low[hsid_pkg::VALID_BIT];
  assign ep_low_f = desc_low[hsid_pkg::EP_LOW_BIT];

  // Address decode
  wire logic                sel_low;
  wire logic                sel_ephi;
  wire logic                sel_poll;
  wire logic                sel_mask;
  wire logic                sel_stat;
  wire logic                sel_dbytes;
  assign sel_low    = (avs_address == hsid_pkg::OFS_DESC_LOW);
  assign sel_ephi   = (avs_address == hsid_pkg::OFS_ENDP_HIGH);
  assign sel_poll   = (avs_address == hsid_pkg::OFS_POLL_FRAME);
  assign sel_mask   = (avs_address == hsid_pkg::OFS_UF_MASK);
  assign sel_stat   = (avs_address == hsid_pkg::OFS_STATUS);
  assign sel_dbytes = (avs_address == hsid_pkg::OFS_DONE_BYTES);

  // Byte-lane merge for the descriptor word
  wire logic [31:0]         be_mask;
  wire logic [31:0]         low_merged;
  assign be_mask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign low_merged = (avs_writedata & be_mask) | (desc_low & ~be_mask);

  wire logic                wr_low;
  wire logic                wr_low_arm;
  assign wr_low     = avs_write & sel_low;
  // Arming happens only when the write sets valid with lane 0 enabled
  assign wr_low_arm = wr_low & avs_byteenable[0] & avs_writedata[hsid_pkg::VALID_BIT];

  // Configuration registers live in lane 0 only
  wire logic                wr_cfg;
  assign wr_cfg     = avs_write & avs_byteenable[0];

  // Poll decision for this microframe
  wire logic                poll_hit;
  hsid_poll_match u_match (
    .rate_code  (poll_frame[hsid_pkg::POLL_RATE_HI:hsid_pkg::POLL_RATE_LO]),
    .frame_num  (frame_num),
    .uframe_idx (uframe_idx),
    .uf_mask    (uf_mask),
    .poll_hit   (poll_hit)
  );

  wire logic                sched_go;
  // Multiplier code 00 is undefined, so it never starts a poll
  assign sched_go = st_idle & usof_pulse & poll_hit & valid_f
                    & (mult_f != 2'b00);

  // Payload accounting on packet completion
  wire logic [14:0]         pkt_bytes;
  wire logic [14:0]         left_after;
  wire logic                short_pkt;
  wire logic                all_moved;
  wire logic                pkt_finish;
  wire logic                xfer_end;
  assign pkt_bytes  = {4'h0, txn_bytes};
  assign left_after = (pkt_bytes >= bytes_left) ? 15'h0000 : (bytes_left - pkt_bytes);
  assign short_pkt  = (txn_bytes < maxpkt_f);
  assign all_moved  = (left_after == 15'h0000);
  // Engine pulses outside the wait state are ignored
  assign pkt_finish = st_wait & txn_done;
  // A fatal error, the last byte or a short packet ends the descriptor
  assign xfer_end   = (st_wait & txn_fatal)
                      | (pkt_finish & (all_moved | short_pkt));

  // Packet length: never more than max packet or what is left
  wire logic [10:0]         len_pick;
  assign len_pick = (bytes_left < {4'h0, maxpkt_f}) ? bytes_left[10:0] : maxpkt_f;

  // Scheduler next state
  always_comb begin
    next_state = state;
    unique case (state)
      hsid_pkg::HSID_IDLE: begin
        if (sched_go) begin
          next_state = hsid_pkg::HSID_ISSUE;
        end
      end
      hsid_pkg::HSID_ISSUE: begin
        next_state = hsid_pkg::HSID_WAIT;
      end
      hsid_pkg::HSID_WAIT: begin
        if (xfer_end) begin
          next_state = hsid_pkg::HSID_IDLE;
        end else if (pkt_finish) begin
          // Back-to-back packets until the multiplier is used up
          next_state = (pkts_left == 2'b01) ? hsid_pkg::HSID_IDLE
                                            : hsid_pkg::HSID_ISSUE;
        end
      end
      default: begin
        // Code 10 is never used; recover to idle
        next_state = hsid_pkg::HSID_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= hsid_pkg::HSID_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Descriptor word; a software write wins over the hardware clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      desc_low <= hsid_pkg::RST_DESC_LOW;
    end else if (wr_low) begin
      desc_low <= low_merged;
    end else if (xfer_end) begin
      desc_low[hsid_pkg::VALID_BIT] <= 1'b0;
    end
  end

  // Remaining polling and endpoint configuration
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ep_high    <= hsid_pkg::RST_EP_HIGH;
      poll_frame <= hsid_pkg::RST_POLL;
      uf_mask    <= hsid_pkg::RST_UF_MASK;
    end else if (wr_cfg) begin
      if (sel_ephi) begin
        ep_high <= avs_writedata[2:0];
      end
      if (sel_poll) begin
        poll_frame <= avs_writedata[7:0];
      end
      if (sel_mask) begin
        uf_mask <= avs_writedata[7:0];
      end
    end
  end

  // Byte counters: loaded on arming, consumed per packet
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bytes_left <= 15'h0000;
      bytes_done <= 15'h0000;
    end else if (wr_low_arm) begin
      bytes_left <= low_merged[hsid_pkg::XFER_HI:hsid_pkg::XFER_LO];
      bytes_done <= 15'h0000;
    end else if (pkt_finish) begin
      bytes_left <= left_after;
      bytes_done <= bytes_done + pkt_bytes;
    end
  end

  // Packets allowed in this execution
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pkts_left <= 2'b00;
    end else if (sched_go) begin
      pkts_left <= mult_f;
    end else if (pkt_finish & (pkts_left != 2'b00)) begin
      pkts_left <= pkts_left - 2'b01;
    end
  end

  // Sticky flags; a new event wins over the clear by arming
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_flag  <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      if (st_wait & txn_fatal) begin
        err_flag <= 1'b1;
      end else if (wr_low_arm) begin
        err_flag <= 1'b0;
      end
      if (xfer_end & ~txn_fatal) begin
        done_flag <= 1'b1;
      end else if (wr_low_arm) begin
        done_flag <= 1'b0;
      end
    end
  end

  // Length of a follow-on packet, from what is left after this one
  wire logic [10:0]         len_next;
  assign len_next = (left_after < {4'h0, maxpkt_f}) ? left_after[10:0] : maxpkt_f;

  // Transaction outputs latched when a packet is issued
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txn_endpoint <= 4'h0;
      txn_len      <= 11'h000;
    end else if (next_state == hsid_pkg::HSID_ISSUE) begin
      txn_endpoint <= {ep_high, ep_low_f};
      txn_len      <= st_wait ? len_next : len_pick;
    end
  end

  // Start is combinational so it lines up with the latched length
  assign txn_start  = st_issue;
  // Software polls this to see the descriptor retire
  assign desc_valid = valid_f;

  // Status word
  logic [31:0]              status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[hsid_pkg::ST_BUSY_BIT] = ~st_idle;
    status_word[hsid_pkg::ST_ERR_BIT]  = err_flag;
    status_word[hsid_pkg::ST_DONE_BIT] = done_flag;
    status_word[hsid_pkg::ST_LEFT_HI:hsid_pkg::ST_LEFT_LO] = pkts_left;
    status_word[hsid_pkg::ST_REM_HI:hsid_pkg::ST_REM_LO]   = bytes_left;
  end

  // Read mux; unmapped addresses read as zero
  wire logic [31:0]         rd_mux;
  assign rd_mux = sel_low    ? desc_low :
                  sel_ephi   ? {29'h0000_0000, ep_high} :
                  sel_poll   ? {24'h00_0000, poll_frame} :
                  sel_mask   ? {24'h00_0000, uf_mask} :
                  sel_stat   ? status_word :
                  sel_dbytes ? {17'h0_0000, bytes_done} :
                  32'h0000_0000;

  // First cycle of a read: latch data, hold the master off
  wire logic                rd_take;
  assign rd_take = avs_read & ~rd_ready;

  // One wait state on reads so read data come from a flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_ready     <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ready <= rd_take;
      if (rd_take) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Writes never wait; a read waits exactly one cycle
  assign avs_waitrequest = rd_take;

endmodule

`default_nettype wire

/* File: tb/hsid_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module hsid_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        usof_pulse,
  input wire logic [2:0]  uframe_idx,
  input wire logic        txn_start,
  input wire logic [3:0]  txn_endpoint,
  input wire logic [10:0] txn_len,
  input wire logic        txn_done,
  input wire logic [10:0] txn_bytes,
  input wire logic        txn_fatal,
  input wire logic        desc_valid
);
  logic [31:0] dsc;
  logic [7:0]  msk;
  logic [4:0]  rte;
  logic [1:0]  cnt;
  logic        bsy;
  // Shadows of software writes; assumes whole-word lanes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dsc <= '0;
      msk <= '0;
      rte <= '0;
    end else if (avs_write && avs_address == hsid_pkg::OFS_DESC_LOW) begin
      dsc <= avs_writedata;
    end else if (avs_write && avs_address == hsid_pkg::OFS_UF_MASK) begin
      msk <= avs_writedata[7:0];
    end else if (avs_write && avs_address == hsid_pkg::OFS_POLL_FRAME) begin
      rte <= avs_writedata[7:3];
    end
  end
  // Packets since the last microframe start, and a busy flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      bsy <= 1'b0;
    end else begin
      cnt <= usof_pulse ? 2'h0 : cnt + 2'(txn_start);
      bsy <= txn_start | (bsy & ~txn_done & ~txn_fatal);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Frame match is only modelled for a zero rate code
  sequence s_hit;
    usof_pulse && desc_valid && !bsy && !txn_start && rte == 5'h0 &&
      msk[uframe_idx] && dsc[30:29] != 2'h0;
  endsequence
  sequence s_short;
    txn_done && bsy && txn_bytes < txn_len && !avs_write;
  endsequence
  AST_MULT_LIMIT: assert property (txn_start |-> cnt < dsc[30:29])
    else $error("too many packets in one poll");
  AST_LEN_CAP: assert property (txn_start |-> txn_len <= dsc[28:18])
    else $error("packet longer than max packet");
  AST_LEN_LEFT: assert property (txn_start |-> txn_len <= dsc[17:3])
    else $error("packet longer than transfer");
  AST_EP_LOW: assert property (txn_start |-> txn_endpoint[0] == dsc[31])
    else $error("endpoint low bit wrong");
  AST_FATAL_CLR: assert property (txn_fatal && bsy && !avs_write |=> !desc_valid)
    else $error("valid kept after fatal");
  AST_SHORT_END: assert property (s_short |=> !desc_valid && !txn_start)
    else $error("short packet did not end");
  AST_SOF_ISSUE: assert property (s_hit |=> txn_start)
    else $error("poll not issued");
  AST_MASK_GATE: assert property (txn_start && !$past(txn_done) |->
    $past(usof_pulse) && msk[$past(uframe_idx)])
    else $error("issue outside masked microframe");
endmodule
bind hsid_top hsid_checker i_chk (.sys_clk, .rst, .avs_address, .avs_write, .avs_writedata,
  .usof_pulse, .uframe_idx, .txn_start, .txn_endpoint, .txn_len, .txn_done, .txn_bytes,
  .txn_fatal, .desc_valid);
`default_nettype wire

/* File: tb/hsid_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hsid_engine_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        txn_start,
  input  wire logic [10:0] txn_len,
  input  wire logic [3:0]  lag,
  input  wire logic        short_pkt,
  input  wire logic        fail,
  output logic             txn_done,
  output logic [10:0]      txn_bytes,
  output logic             txn_fatal
);
  // Answers after lag cycles; byte count is inverted once done drops
  initial begin
    txn_done = 1'b0;
    txn_fatal = 1'b0;
    txn_bytes = '0;
    forever begin
      @(negedge sys_clk);
      if (txn_start === 1'b1 && !rst) begin
        @(posedge sys_clk);
        repeat (lag) @(posedge sys_clk);
        txn_fatal <= fail;
        txn_done <= !fail;
        txn_bytes <= short_pkt ? txn_len - 11'h1 : txn_len;
        @(posedge sys_clk);
        txn_done <= 1'b0;
        txn_fatal <= 1'b0;
        txn_bytes <= ~txn_bytes;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/hsid_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module hsid_top_bench;
  logic        sys_clk, rst, avs_read, avs_write, usof_pulse, avs_waitrequest;
  logic        txn_start, txn_done, txn_fatal, desc_valid, short_pkt, fail;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [4:0]  frame_num;
  logic [2:0]  uframe_idx;
  logic [3:0]  txn_endpoint, lag, last_ep;
  logic [10:0] txn_len, txn_bytes, last_len;
  int          err_count, tests_run, starts;
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  hsid_top i_dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .usof_pulse, .frame_num,
    .uframe_idx, .txn_start, .txn_endpoint, .txn_len, .txn_done, .txn_bytes,
    .txn_fatal, .desc_valid);
  hsid_engine_model i_eng (.sys_clk, .rst, .txn_start, .txn_len, .lag, .short_pkt,
    .fail, .txn_done, .txn_bytes, .txn_fatal);
  // Tally issued packets away from the launch edge
  always @(negedge sys_clk)
    if (txn_start === 1'b1) begin
      starts++;
      last_len = txn_len;
      last_ep = txn_endpoint;
    end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One bus cycle; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // One idle edge so back-to-back calls never reassign in one step
    @(posedge sys_clk);
  endtask
  task automatic load(input logic [1:0] m, input logic [10:0] mp, input logic [14:0] n,
                      input logic ep);
    // Valid goes in with the count; no separate active copy is held here
    bus(1'b1, hsid_pkg::OFS_DESC_LOW, {ep, m, mp, n, 3'h1});
  endtask
  task automatic sof(input logic [4:0] f, input logic [2:0] u, input int exp);
    starts = 0;
    frame_num <= f;
    uframe_idx <= u;
    usof_pulse <= 1'b1;
    @(posedge sys_clk);
    usof_pulse <= 1'b0;
    repeat (60) @(posedge sys_clk);
    cmp(starts, exp);
  endtask
  task automatic t_reset;
    bus(1'b0, hsid_pkg::OFS_STATUS, 32'h0);
    cmp(rd, 32'h0);
    cmp({31'h0, desc_valid}, 32'h0);
    bus(1'b0, 6'h3C, 32'h0);
    cmp(rd, 32'h0);
  endtask
  // Every multiplier code, partner lag varied with it
  task automatic t_mult;
    for (int i = 0; i < 4; i++) begin
      lag <= 4'(i);
      load(2'(i), 11'h4, 15'h28, i[0]);
      sof(5'h0, 3'(i), i);
      bus(1'b0, hsid_pkg::OFS_STATUS, 32'h0);
      cmp({17'h0, rd[30:16]}, 32'(40 - 4 * i));
      if (i > 0) begin
        cmp({28'h0, last_ep}, {28'h0, 3'h5, i[0]});
        cmp({21'h0, last_len}, 32'h4);
      end
    end
  endtask
  // Tail packet shorter than max, then valid drops
  task automatic t_end;
    load(2'h3, 11'h8, 15'h14, 1'b0);
    sof(5'h0, 3'h7, 3);
    cmp({21'h0, last_len}, 32'h4);
    cmp({31'h0, desc_valid}, 32'h0);
    bus(1'b0, hsid_pkg::OFS_STATUS, 32'h0);
    cmp(rd, 32'h0000_0004);
    bus(1'b0, hsid_pkg::OFS_DONE_BYTES, 32'h0);
    cmp(rd, 32'h0000_0014);
  endtask
  task automatic t_mask;
    bus(1'b1, hsid_pkg::OFS_UF_MASK, 32'h55);
    load(2'h1, 11'h8, 15'h28, 1'b1);
    sof(5'h0, 3'h1, 0);
    sof(5'h0, 3'h2, 1);
    bus(1'b1, hsid_pkg::OFS_UF_MASK, 32'h01);
    bus(1'b1, hsid_pkg::OFS_POLL_FRAME, 32'h10);
    sof(5'h1, 3'h0, 0);
    sof(5'h6, 3'h0, 1);
    bus(1'b1, hsid_pkg::OFS_POLL_FRAME, 32'h0);
  endtask
  // Fatal error, then short packet, each ends the transfer early
  task automatic t_fault;
    for (int k = 0; k < 2; k++) begin
      fail <= (k == 0);
      short_pkt <= (k == 1);
      load(2'h2, 11'h8, 15'h28, 1'b0);
      sof(5'h0, 3'h0, 1);
      cmp({31'h0, desc_valid}, 32'h0);
      bus(1'b0, hsid_pkg::OFS_STATUS, 32'h0);
      cmp({29'h0, rd[2:0]}, (k == 0) ? 32'h0000_0002 : 32'h0000_0004);
    end
    fail <= 1'b0;
    short_pkt <= 1'b0;
  endtask
  task automatic stop_test;
    $display("errors %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {rst, avs_read, avs_write, usof_pulse, short_pkt, fail} = 6'h20;
    {avs_address, avs_writedata, frame_num, uframe_idx, lag} = '0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset;
    bus(1'b1, hsid_pkg::OFS_ENDP_HIGH, 32'h5);
    bus(1'b1, hsid_pkg::OFS_UF_MASK, 32'hFF);
    t_mult;
    t_end;
    t_mask;
    t_fault;
    stop_test;
  end
  // Run needs about 730 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end
endmodule
`default_nettype wire
